// [rtl/bitmanip_pkg.sv]
`default_nettype none
package bitmanip_pkg;
    // ==========================================
    // Widths and reset values
    localparam int XLEN = 64;
    localparam int WORD = 32;
    localparam int SHAMT_W = 6;
    localparam int IMM_W = 7;
    localparam int CNT_W = 7;
    localparam logic HAS_ZBC = 1'b1;
    localparam logic [63:0] RESULT_RST = 64'h0;
    localparam logic [31:0] WORD_ONES = 32'hffffffff;
    localparam logic [31:0] WORD_ZERO = 32'h0;

    // ==========================================
    // Counter modes
    localparam logic [1:0] CNT_TRAIL = 2'h0;
    localparam logic [1:0] CNT_LEAD = 2'h1;
    localparam logic [1:0] CNT_POP = 2'h2;

    // ==========================================
    // Operation codes, one per instruction whatever group lists it
    typedef enum logic [5:0] {
        OP_ADD_UW = 6'h00, OP_SH1ADD = 6'h01, OP_SH2ADD = 6'h02, OP_SH3ADD = 6'h03,
        OP_SH1ADD_UW = 6'h04, OP_SH2ADD_UW = 6'h05, OP_SH3ADD_UW = 6'h06, OP_SLLI_UW = 6'h07,
        OP_ANDN = 6'h08, OP_ORN = 6'h09, OP_XNOR = 6'h0a, OP_CLZ = 6'h0b,
        OP_CLZW = 6'h0c, OP_CTZ = 6'h0d, OP_CTZW = 6'h0e, OP_CPOP = 6'h0f,
        OP_CPOPW = 6'h10, OP_MAX = 6'h11, OP_MAXU = 6'h12, OP_MIN = 6'h13,
        OP_MINU = 6'h14, OP_SEXT_B = 6'h15, OP_SEXT_H = 6'h16, OP_ZEXT_H = 6'h17,
        OP_ROL = 6'h18, OP_ROLW = 6'h19, OP_ROR = 6'h1a, OP_RORI = 6'h1b,
        OP_RORIW = 6'h1c, OP_RORW = 6'h1d, OP_ORC_B = 6'h1e, OP_REV8 = 6'h1f,
        OP_CLMUL = 6'h20, OP_CLMULH = 6'h21, OP_CLMULR = 6'h22, OP_BCLR = 6'h23,
        OP_BCLRI = 6'h24, OP_BEXT = 6'h25, OP_BEXTI = 6'h26, OP_BINV = 6'h27,
        OP_BINVI = 6'h28, OP_BSET = 6'h29, OP_BSETI = 6'h2a
    } op_t;
endpackage : bitmanip_pkg
`default_nettype wire

// [rtl/count_if.sv]
`default_nettype none
interface count_if;
    logic [63:0] value;
    logic [1:0] mode;
    logic [6:0] count;
    modport user (output value, output mode, input count);
    modport unit (input value, input mode, output count);
endinterface : count_if
`default_nettype wire

// [rtl/zero_count_unit.sv]
`default_nettype none
module zero_count_unit (
    count_if.unit cnt
);
    // ==========================================
    // Bit order reversal so leading counts reuse the trailing scan
    logic [63:0] rev_value;
    logic [63:0] scan_value;
    genvar gi;
    generate
        for (gi = 0; gi < 64; gi++) begin : g_rev
            assign rev_value[gi] = cnt.value[63 - gi];
        end
    endgenerate
    assign scan_value = (cnt.mode == bitmanip_pkg::CNT_LEAD) ? rev_value : cnt.value;

    // Trailing zero scan and population count
    always_comb begin
        logic found;
        logic [6:0] trail;
        logic [6:0] pop;
        found = 1'b0;
        trail = 7'h0;
        pop = 7'h0;
        for (int i = 0; i < 64; i++) begin
            if (scan_value[i]) begin
                found = 1'b1;
                pop = pop + 7'h1;
            end else if (!found) begin
                trail = trail + 7'h1;
            end
        end
        cnt.count = (cnt.mode == bitmanip_pkg::CNT_POP) ? pop : trail;
    end
endmodule : zero_count_unit
`default_nettype wire

// [rtl/bitmanip_execution_unit.sv]
// What this block does
// [RULE1] Word ops use low 32 bits, sign-extend
// [RULE2] Unsigned-word ops zero-extend one operand
// [RULE3] Byte/half/word suffixes read only low bits
// [RULE4] Shift immediates decode six bits, seventh reserved
// [RULE5] Shared instructions use one encoding, datapath
// [RULE6] Address, basic, single-bit groups; carry-less optional
// [RULE7] Shift-add shifts first source 1-3, adds
// [RULE8] Unsigned-word shift-add zero-extends first source
// [RULE9] Shift-left unsigned word zero-extends then shifts
// [RULE10] AND/OR with inverted second source
// [RULE11] Count leading and trailing zeros, full width
// [RULE12] Word zero counts within low word
// [RULE13] Population count, full or low word
// [RULE14] OR-combine fills each nonzero byte ones
// [RULE15] Rotate left word by register amount
// [RULE16] Rotate right word by immediate or register
// [RULE17] Rotates wrap shifted-out bits around
// [RULE18] Set, clear, invert, extract indexed bit
// [RULE19] Carry-less product low, high, reversed halves
// [RULE20] Byte reverse full register
// [RULE21] Signed and unsigned minimum and maximum
// [RULE22] Exclusive NOR and byte/half extensions
`default_nettype none
module bitmanip_execution_unit (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic issue_valid,
    input wire bitmanip_pkg::op_t op_sel,
    input wire logic [63:0] src_a,
    input wire logic [63:0] src_b,
    input wire logic [6:0] shamt_field,
    output logic [63:0] result_reg,
    output logic done_reg,
    output logic illegal_reg
);
    // ==========================================
    // Operand preparation
    logic imm_form;
    logic word_imm;
    logic [5:0] amt;
    logic [63:0] a_uw;
    logic [31:0] a_lo;
    assign imm_form = (op_sel == bitmanip_pkg::OP_RORI) || (op_sel == bitmanip_pkg::OP_RORIW) ||
                      (op_sel == bitmanip_pkg::OP_SLLI_UW) || (op_sel == bitmanip_pkg::OP_BCLRI) ||
                      (op_sel == bitmanip_pkg::OP_BEXTI) || (op_sel == bitmanip_pkg::OP_BINVI) ||
                      (op_sel == bitmanip_pkg::OP_BSETI);
    assign word_imm = (op_sel == bitmanip_pkg::OP_RORIW);
    // Register and immediate forms share one amount path
    assign amt = imm_form ? shamt_field[5:0] : src_b[5:0]; // [RULE4] [RULE5]
    assign a_uw = {bitmanip_pkg::WORD_ZERO, src_a[31:0]}; // [RULE2]
    assign a_lo = src_a[31:0]; // [RULE1]

    // ==========================================
    // Shift and add address generation
    logic uw_add;
    logic [1:0] sh_sel;
    logic [63:0] sh_base;
    logic [63:0] sh_sum;
    logic [63:0] slli_uw_val;
    assign uw_add = (op_sel == bitmanip_pkg::OP_ADD_UW) || (op_sel == bitmanip_pkg::OP_SH1ADD_UW) ||
                    (op_sel == bitmanip_pkg::OP_SH2ADD_UW) || (op_sel == bitmanip_pkg::OP_SH3ADD_UW);
    assign sh_sel = ((op_sel == bitmanip_pkg::OP_SH1ADD) || (op_sel == bitmanip_pkg::OP_SH1ADD_UW)) ? 2'h1 :
                    ((op_sel == bitmanip_pkg::OP_SH2ADD) || (op_sel == bitmanip_pkg::OP_SH2ADD_UW)) ? 2'h2 :
                    ((op_sel == bitmanip_pkg::OP_SH3ADD) || (op_sel == bitmanip_pkg::OP_SH3ADD_UW)) ? 2'h3 :
                    2'h0;
    assign sh_base = uw_add ? a_uw : src_a; // [RULE8]
    assign sh_sum = (sh_base << sh_sel) + src_b; // [RULE7] [RULE8]
    assign slli_uw_val = a_uw << amt; // [RULE9]

    // ==========================================
    // Logic with inverted operand
    logic [63:0] andn_val;
    logic [63:0] orn_val;
    logic [63:0] xnor_val;
    assign andn_val = src_a & ~src_b; // [RULE10]
    assign orn_val = src_a | ~src_b; // [RULE10]
    assign xnor_val = ~(src_a ^ src_b); // [RULE22]

    // ==========================================
    // Zero and population counts through the shared counter
    count_if cnt ();
    logic [1:0] cnt_mode;
    logic [63:0] cnt_value;
    assign cnt_mode = ((op_sel == bitmanip_pkg::OP_CLZ) || (op_sel == bitmanip_pkg::OP_CLZW)) ?
                      bitmanip_pkg::CNT_LEAD :
                      ((op_sel == bitmanip_pkg::OP_CPOP) || (op_sel == bitmanip_pkg::OP_CPOPW)) ?
                      bitmanip_pkg::CNT_POP : bitmanip_pkg::CNT_TRAIL;
    // Word forms pad the unused word, the lower one for CLZW, so the count stops at 32
    assign cnt_value = (op_sel == bitmanip_pkg::OP_CLZW) ? {a_lo, bitmanip_pkg::WORD_ONES} : // [RULE12]
                       (op_sel == bitmanip_pkg::OP_CTZW) ? {bitmanip_pkg::WORD_ONES, a_lo} : // [RULE12]
                       (op_sel == bitmanip_pkg::OP_CPOPW) ? a_uw : src_a; // [RULE13] [RULE11]
    assign cnt.value = cnt_value;
    assign cnt.mode = cnt_mode;
    zero_count_unit u_count (
        .cnt(cnt.unit)
    );
    logic [63:0] cnt_result;
    assign cnt_result = {57'h0, cnt.count}; // [RULE11] [RULE13]

    // ==========================================
    // Minimum and maximum
    logic lt_s;
    logic lt_u;
    assign lt_s = $signed(src_a) < $signed(src_b); // [RULE21]
    assign lt_u = src_a < src_b; // [RULE21]

    // ==========================================
    // Sign and zero extension of low byte or halfword
    logic [63:0] sext_b_val;
    logic [63:0] sext_h_val;
    logic [63:0] zext_h_val;
    assign sext_b_val = {{56{src_a[7]}}, src_a[7:0]}; // [RULE3] [RULE22]
    assign sext_h_val = {{48{src_a[15]}}, src_a[15:0]}; // [RULE3] [RULE22]
    assign zext_h_val = {48'h0, src_a[15:0]}; // [RULE3] [RULE22]

    // ==========================================
    // Rotates: a doubled operand shifted right wraps bits around
    logic right_rot;
    logic [5:0] rot_amt;
    logic [4:0] rot_amt_w;
    logic [127:0] rot_dbl;
    logic [63:0] rot_wdbl;
    logic [63:0] rot_val;
    logic [63:0] rot_w_val;
    assign right_rot = (op_sel == bitmanip_pkg::OP_ROR) || (op_sel == bitmanip_pkg::OP_RORI) ||
                       (op_sel == bitmanip_pkg::OP_RORW) || (op_sel == bitmanip_pkg::OP_RORIW);
    // Left rotation by n is right rotation by minus n
    assign rot_amt = right_rot ? amt : 6'(6'h0 - amt); // [RULE17]
    assign rot_amt_w = right_rot ? amt[4:0] : 5'(5'h0 - amt[4:0]); // [RULE15] [RULE16]
    assign rot_dbl = {src_a, src_a} >> rot_amt; // [RULE17]
    assign rot_wdbl = {a_lo, a_lo} >> rot_amt_w; // [RULE15] [RULE16]
    assign rot_val = rot_dbl[63:0];
    assign rot_w_val = {{32{rot_wdbl[31]}}, rot_wdbl[31:0]}; // [RULE1]

    // ==========================================
    // OR-combine and byte reverse
    logic [63:0] orc_val;
    logic [63:0] rev8_val;
    genvar gb;
    generate
        for (gb = 0; gb < 8; gb++) begin : g_byte
            assign orc_val[8 * gb +: 8] = {8{|src_a[8 * gb +: 8]}}; // [RULE14]
            assign rev8_val[8 * gb +: 8] = src_a[8 * (7 - gb) +: 8]; // [RULE20]
        end
    endgenerate

    // ==========================================
    // Carry-less product as a chain of partial XORs
    logic [127:0] cl_part [0:64];
    assign cl_part[0] = 128'h0;
    genvar gc;
    generate
        for (gc = 0; gc < 64; gc++) begin : g_clmul
            assign cl_part[gc + 1] = cl_part[gc] ^ (src_b[gc] ? ({64'h0, src_a} << gc) : 128'h0); // [RULE19]
        end
    endgenerate
    logic [127:0] cl_prod;
    assign cl_prod = cl_part[64];

    // ==========================================
    // Single-bit operations
    logic [63:0] bit_mask;
    logic [63:0] bext_val;
    assign bit_mask = 64'h1 << amt; // [RULE18]
    assign bext_val = {63'h0, |(src_a & bit_mask)}; // [RULE18]

    // ==========================================
    // Illegal encodings
    logic bad_imm;
    logic bad_group;
    assign bad_imm = imm_form && (shamt_field[6] || (word_imm && shamt_field[5])); // [RULE4]
    assign bad_group = !bitmanip_pkg::HAS_ZBC && ((op_sel == bitmanip_pkg::OP_CLMUL) || // [RULE6]
                       (op_sel == bitmanip_pkg::OP_CLMULH) || (op_sel == bitmanip_pkg::OP_CLMULR));

    // ==========================================
    // Result selection
    logic [63:0] sel_val;
    logic known_op;
    always_comb begin
        sel_val = bitmanip_pkg::RESULT_RST;
        known_op = 1'b1;
        case (op_sel)
            bitmanip_pkg::OP_ADD_UW, bitmanip_pkg::OP_SH1ADD, bitmanip_pkg::OP_SH2ADD,
            bitmanip_pkg::OP_SH3ADD, bitmanip_pkg::OP_SH1ADD_UW, bitmanip_pkg::OP_SH2ADD_UW,
            bitmanip_pkg::OP_SH3ADD_UW: sel_val = sh_sum;
            bitmanip_pkg::OP_SLLI_UW: sel_val = slli_uw_val;
            bitmanip_pkg::OP_ANDN: sel_val = andn_val;
            bitmanip_pkg::OP_ORN: sel_val = orn_val;
            bitmanip_pkg::OP_XNOR: sel_val = xnor_val;
            bitmanip_pkg::OP_CLZ, bitmanip_pkg::OP_CLZW, bitmanip_pkg::OP_CTZ, bitmanip_pkg::OP_CTZW,
            bitmanip_pkg::OP_CPOP, bitmanip_pkg::OP_CPOPW: sel_val = cnt_result;
            bitmanip_pkg::OP_MAX: sel_val = lt_s ? src_b : src_a; // [RULE21]
            bitmanip_pkg::OP_MAXU: sel_val = lt_u ? src_b : src_a; // [RULE21]
            bitmanip_pkg::OP_MIN: sel_val = lt_s ? src_a : src_b; // [RULE21]
            bitmanip_pkg::OP_MINU: sel_val = lt_u ? src_a : src_b; // [RULE21]
            bitmanip_pkg::OP_SEXT_B: sel_val = sext_b_val;
            bitmanip_pkg::OP_SEXT_H: sel_val = sext_h_val;
            bitmanip_pkg::OP_ZEXT_H: sel_val = zext_h_val;
            bitmanip_pkg::OP_ROL, bitmanip_pkg::OP_ROR, bitmanip_pkg::OP_RORI: sel_val = rot_val;
            bitmanip_pkg::OP_ROLW, bitmanip_pkg::OP_RORW, bitmanip_pkg::OP_RORIW: sel_val = rot_w_val;
            bitmanip_pkg::OP_ORC_B: sel_val = orc_val;
            bitmanip_pkg::OP_REV8: sel_val = rev8_val;
            bitmanip_pkg::OP_CLMUL: sel_val = cl_prod[63:0]; // [RULE19]
            bitmanip_pkg::OP_CLMULH: sel_val = cl_prod[127:64]; // [RULE19]
            bitmanip_pkg::OP_CLMULR: sel_val = cl_prod[126:63]; // [RULE19]
            bitmanip_pkg::OP_BCLR, bitmanip_pkg::OP_BCLRI: sel_val = src_a & ~bit_mask; // [RULE18]
            bitmanip_pkg::OP_BEXT, bitmanip_pkg::OP_BEXTI: sel_val = bext_val;
            bitmanip_pkg::OP_BINV, bitmanip_pkg::OP_BINVI: sel_val = src_a ^ bit_mask; // [RULE18]
            bitmanip_pkg::OP_BSET, bitmanip_pkg::OP_BSETI: sel_val = src_a | bit_mask; // [RULE18]
            default: known_op = 1'b0;
        endcase
    end

    logic op_bad;
    logic [63:0] result_next;
    assign op_bad = !known_op || bad_imm || bad_group;
    assign result_next = op_bad ? bitmanip_pkg::RESULT_RST : sel_val;

    // ==========================================
    // Result registers, frozen while srst is low and the clock enable is low
    bitmanip_pkg::op_t op_reg;
    logic [63:0] a_reg;
    logic [63:0] b_reg;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            result_reg <= bitmanip_pkg::RESULT_RST;
            done_reg <= 1'b0;
            illegal_reg <= 1'b0;
            op_reg <= bitmanip_pkg::OP_ADD_UW;
            a_reg <= bitmanip_pkg::RESULT_RST;
            b_reg <= bitmanip_pkg::RESULT_RST;
        end else if (clk_en) begin
            done_reg <= issue_valid;
            if (issue_valid) begin
                result_reg <= result_next;
                illegal_reg <= op_bad;
                op_reg <= op_sel;
                a_reg <= src_a;
                b_reg <= src_b;
            end
        end
    end

    // ==========================================
    // Checks on the registered result
    logic ok_out;
    assign ok_out = done_reg && !illegal_reg;

    a_word_signext: assert property (@(posedge ref_clk) disable iff (srst) // [RULE1]
        ok_out && (op_reg == bitmanip_pkg::OP_ROLW || op_reg == bitmanip_pkg::OP_RORW ||
        op_reg == bitmanip_pkg::OP_RORIW) |-> result_reg[63:32] == {32{result_reg[31]}})
        else $error("word result not sign extended");
    a_uw_add: assert property (@(posedge ref_clk) disable iff (srst) // [RULE8]
        ok_out && op_reg == bitmanip_pkg::OP_SH2ADD_UW |->
        result_reg == 64'(({32'h0, a_reg[31:0]} << 2) + b_reg))
        else $error("unsigned word shift add wrong");
    a_sh3_add: assert property (@(posedge ref_clk) disable iff (srst) // [RULE7]
        ok_out && op_reg == bitmanip_pkg::OP_SH3ADD |-> result_reg == 64'((a_reg << 3) + b_reg))
        else $error("shift by three and add wrong");
    a_andn_clear: assert property (@(posedge ref_clk) disable iff (srst) // [RULE10]
        ok_out && op_reg == bitmanip_pkg::OP_ANDN |-> (result_reg & b_reg) == 64'h0)
        else $error("and-not kept bits of second source");
    a_clz_range: assert property (@(posedge ref_clk) disable iff (srst) // [RULE11]
        ok_out && op_reg == bitmanip_pkg::OP_CLZ |-> (result_reg == 64'h40) == (a_reg == 64'h0))
        else $error("leading count of zero operand wrong");
    a_clzw_range: assert property (@(posedge ref_clk) disable iff (srst) // [RULE12]
        ok_out && op_reg == bitmanip_pkg::OP_CLZW |-> result_reg <= 64'h20)
        else $error("word leading count above 32");
    a_orc_bytes: assert property (@(posedge ref_clk) disable iff (srst) // [RULE14]
        ok_out && op_reg == bitmanip_pkg::OP_ORC_B |-> (result_reg[7:0] == 8'h0) == (a_reg[7:0] == 8'h0))
        else $error("or-combine byte wrong");
    a_rot_pop: assert property (@(posedge ref_clk) disable iff (srst) // [RULE17]
        ok_out && (op_reg == bitmanip_pkg::OP_ROL || op_reg == bitmanip_pkg::OP_ROR) |->
        $countones(result_reg) == $countones(a_reg))
        else $error("rotate lost bits");
    a_rev8_ends: assert property (@(posedge ref_clk) disable iff (srst) // [RULE20]
        ok_out && op_reg == bitmanip_pkg::OP_REV8 |-> result_reg[7:0] == a_reg[63:56])
        else $error("byte reverse wrong");
    a_max_signed: assert property (@(posedge ref_clk) disable iff (srst) // [RULE21]
        ok_out && op_reg == bitmanip_pkg::OP_MAX |->
        $signed(result_reg) >= $signed(a_reg) && $signed(result_reg) >= $signed(b_reg))
        else $error("signed maximum too small");
    a_shamt_reject: assert property (@(posedge ref_clk) disable iff (srst) // [RULE4]
        clk_en && issue_valid && op_sel == bitmanip_pkg::OP_RORI && shamt_field[6] |=> illegal_reg && done_reg)
        else $error("seventh shift bit not rejected");
    a_issue_done: assert property (@(posedge ref_clk) disable iff (srst)
        clk_en && issue_valid |=> done_reg)
        else $error("result not ready one cycle after issue");
    a_freeze_hold: assert property (@(posedge ref_clk) disable iff (srst)
        !clk_en |=> $stable(result_reg) && $stable(done_reg) && $stable(illegal_reg))
        else $error("outputs moved while clock enable low");

    c_clmul: cover property (@(posedge ref_clk) disable iff (srst) ok_out && op_reg == bitmanip_pkg::OP_CLMULR);
    c_roriw: cover property (@(posedge ref_clk) disable iff (srst) ok_out && op_reg == bitmanip_pkg::OP_RORIW);
    c_shadd_uw: cover property (@(posedge ref_clk) disable iff (srst) ok_out && op_reg == bitmanip_pkg::OP_SH3ADD_UW);
    c_illegal: cover property (@(posedge ref_clk) disable iff (srst) done_reg && illegal_reg);
endmodule : bitmanip_execution_unit
`default_nettype wire

// [sim/pipe_model.sv]
`default_nettype none
module pipe_model (
    input wire logic ref_clk,
    output var logic issue_valid,
    output var bitmanip_pkg::op_t op_sel,
    output var logic [63:0] src_a,
    output var logic [63:0] src_b,
    output var logic [6:0] shamt_field,
    input wire logic [63:0] result_reg,
    input wire logic done_reg,
    input wire logic illegal_reg
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================
    // Writeback capture
    logic [63:0] wb_result;
    logic wb_done;
    logic wb_illegal;

    // Idle operand lines carry no stale copy of the last request
    initial begin
        issue_valid = 1'b0;
        op_sel = bitmanip_pkg::OP_ADD_UW;
        src_a = 64'h0;
        src_b = 64'h0;
        shamt_field = 7'h0;
    end

    // One issue slot, then operands scrambled and writeback taken
    task issue(input bitmanip_pkg::op_t op, input logic [63:0] a, input logic [63:0] b, input logic [6:0] sh);
        @(negedge ref_clk);
        issue_valid = 1'b1;
        op_sel = op;
        src_a = a;
        src_b = b;
        shamt_field = sh;
        @(negedge ref_clk);
        issue_valid = 1'b0;
        src_a = ~src_a;
        src_b = ~src_b;
        shamt_field = ~shamt_field;
        wb_result = result_reg;
        wb_done = done_reg;
        wb_illegal = illegal_reg;
    endtask : issue
endmodule : pipe_model
`default_nettype wire

// [sim/bitmanip_execution_unit_bench.sv]
`default_nettype none
module bitmanip_execution_unit_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================
    // Clock, reset and wiring
    logic ref_clk;
    logic srst;
    logic clk_en;
    logic issue_valid;
    bitmanip_pkg::op_t op_sel;
    logic [63:0] src_a;
    logic [63:0] src_b;
    logic [6:0] shamt_field;
    logic [63:0] result_reg;
    logic done_reg;
    logic illegal_reg;
    int n_fail = 0;
    int check_count = 0;

    // Free-running 50 ns clock
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    bitmanip_execution_unit bitmanip_execution_unit_inst (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en),
        .issue_valid(issue_valid), .op_sel(op_sel), .src_a(src_a), .src_b(src_b), .shamt_field(shamt_field),
        .result_reg(result_reg), .done_reg(done_reg), .illegal_reg(illegal_reg));

    pipe_model pipe_model_inst (.ref_clk(ref_clk), .issue_valid(issue_valid), .op_sel(op_sel), .src_a(src_a),
        .src_b(src_b), .shamt_field(shamt_field), .result_reg(result_reg), .done_reg(done_reg),
        .illegal_reg(illegal_reg));

    // ==========================================
    // Compare and report
    task chk64(input string what, input logic [63:0] exp, input logic [63:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk64

    task chk1(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask : chk1

    task close_out;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    // Issue one operation and judge its writeback
    task run(input bitmanip_pkg::op_t op, input logic [63:0] a, input logic [63:0] b, input logic [6:0] sh,
             input logic [63:0] exp, input logic ill = 1'b0);
        pipe_model_inst.issue(op, a, b, sh);
        chk64(op.name(), exp, pipe_model_inst.wb_result);
        chk1("done", 1'b1, pipe_model_inst.wb_done);
        chk1("illegal", ill, pipe_model_inst.wb_illegal);
    endtask : run

    // ==========================================
    // Scenarios
    task t_zba;
        run(bitmanip_pkg::OP_SH1ADD, 64'h10, 64'h3, 7'h0, 64'h23);
        run(bitmanip_pkg::OP_SH3ADD, 64'hffffffffffffffff, 64'h10, 7'h0, 64'h8);
        run(bitmanip_pkg::OP_ADD_UW, 64'hffffffff80000000, 64'h1, 7'h0, 64'h80000001);
        run(bitmanip_pkg::OP_SH1ADD_UW, 64'h100000001, 64'h10, 7'h0, 64'h12);
        run(bitmanip_pkg::OP_SH2ADD_UW, 64'hffffffffffffffff, 64'h0, 7'h0, 64'h3fffffffc);
        run(bitmanip_pkg::OP_SH3ADD_UW, 64'h8000000000000002, 64'h1, 7'h0, 64'h11);
        run(bitmanip_pkg::OP_SLLI_UW, 64'hffffffff80000001, 64'h0, 7'h4, 64'h800000010);
    endtask : t_zba

    task t_logic;
        run(bitmanip_pkg::OP_ANDN, 64'hff00, 64'h0f00, 7'h0, 64'hf000);
        run(bitmanip_pkg::OP_ORN, 64'h0, 64'hffffffffffff0000, 7'h0, 64'hffff);
        run(bitmanip_pkg::OP_XNOR, 64'hf0, 64'hff, 7'h0, 64'hfffffffffffffff0);
        run(bitmanip_pkg::OP_ORC_B, 64'h0100000080000020, 64'h0, 7'h0, 64'hff000000ff0000ff);
        run(bitmanip_pkg::OP_REV8, 64'h0102030405060708, 64'h0, 7'h0, 64'h0807060504030201);
    endtask : t_logic

    task t_count;
        run(bitmanip_pkg::OP_CLZ, 64'h10000, 64'h0, 7'h0, 64'h2f);
        run(bitmanip_pkg::OP_CLZ, 64'h0, 64'h0, 7'h0, 64'h40);
        run(bitmanip_pkg::OP_CTZ, 64'h100, 64'h0, 7'h0, 64'h8);
        run(bitmanip_pkg::OP_CTZ, 64'h0, 64'h0, 7'h0, 64'h40);
        run(bitmanip_pkg::OP_CLZW, 64'hffffffff00000100, 64'h0, 7'h0, 64'h17);
        run(bitmanip_pkg::OP_CTZW, 64'h100000000, 64'h0, 7'h0, 64'h20);
        run(bitmanip_pkg::OP_CPOP, 64'hffffffffffffffff, 64'h0, 7'h0, 64'h40);
        run(bitmanip_pkg::OP_CPOPW, 64'hffff0000000000ff, 64'h0, 7'h0, 64'h8);
    endtask : t_count

    task t_minmax_ext;
        run(bitmanip_pkg::OP_MAX, 64'hffffffffffffffff, 64'h1, 7'h0, 64'h1);
        run(bitmanip_pkg::OP_MAXU, 64'hffffffffffffffff, 64'h1, 7'h0, 64'hffffffffffffffff);
        run(bitmanip_pkg::OP_MIN, 64'hffffffffffffffff, 64'h1, 7'h0, 64'hffffffffffffffff);
        run(bitmanip_pkg::OP_MINU, 64'hffffffffffffffff, 64'h1, 7'h0, 64'h1);
        run(bitmanip_pkg::OP_SEXT_B, 64'h12340080, 64'h0, 7'h0, 64'hffffffffffffff80);
        run(bitmanip_pkg::OP_SEXT_H, 64'hffffffffffff7fff, 64'h0, 7'h0, 64'h7fff);
        run(bitmanip_pkg::OP_ZEXT_H, 64'hffffffffffff8001, 64'h0, 7'h0, 64'h8001);
    endtask : t_minmax_ext

    task t_rotate;
        run(bitmanip_pkg::OP_ROL, 64'h8000000000000001, 64'h4, 7'h0, 64'h18);
        run(bitmanip_pkg::OP_ROR, 64'h1, 64'h41, 7'h0, 64'h8000000000000000);
        run(bitmanip_pkg::OP_RORI, 64'hf, 64'h0, 7'h4, 64'hf000000000000000);
        run(bitmanip_pkg::OP_ROLW, 64'hdeadbeef80000001, 64'h1, 7'h0, 64'h3);
        run(bitmanip_pkg::OP_RORW, 64'h1, 64'h1, 7'h0, 64'hffffffff80000000);
        run(bitmanip_pkg::OP_RORIW, 64'hffffffff00000001, 64'h0, 7'h1f, 64'h2);
    endtask : t_rotate

    task t_single_bit;
        run(bitmanip_pkg::OP_BSET, 64'h0, 64'h3f, 7'h0, 64'h8000000000000000);
        run(bitmanip_pkg::OP_BCLR, 64'hffffffffffffffff, 64'h0, 7'h0, 64'hfffffffffffffffe);
        run(bitmanip_pkg::OP_BINV, 64'h10, 64'h4, 7'h0, 64'h0);
        run(bitmanip_pkg::OP_BEXT, 64'h8000000000000000, 64'h3f, 7'h0, 64'h1);
        run(bitmanip_pkg::OP_BSETI, 64'h0, 64'h0, 7'h20, 64'h100000000);
        run(bitmanip_pkg::OP_BCLRI, 64'hffffffffffffffff, 64'h0, 7'h3f, 64'h7fffffffffffffff);
        run(bitmanip_pkg::OP_BINVI, 64'h0, 64'h0, 7'h1, 64'h2);
        run(bitmanip_pkg::OP_BEXTI, 64'h4, 64'h0, 7'h2, 64'h1);
    endtask : t_single_bit

    task t_clmul;
        run(bitmanip_pkg::OP_CLMUL, 64'h3, 64'h3, 7'h0, 64'h5);
        run(bitmanip_pkg::OP_CLMULH, 64'h8000000000000000, 64'h2, 7'h0, 64'h1);
        run(bitmanip_pkg::OP_CLMULR, 64'h8000000000000000, 64'h1, 7'h0, 64'h1);
    endtask : t_clmul

    task t_refused;
        run(bitmanip_pkg::OP_RORI, 64'hf, 64'h0, 7'h44, 64'h0, 1'b1);
        run(bitmanip_pkg::OP_RORIW, 64'hf, 64'h0, 7'h21, 64'h0, 1'b1);
        run(bitmanip_pkg::op_t'(6'h3f), 64'hf, 64'hf, 7'h0, 64'h0, 1'b1);
        run(bitmanip_pkg::OP_SH2ADD, 64'h1, 64'ha, 7'h0, 64'he);
    endtask : t_refused

    // Result holds once done falls, and a frozen clock enable ignores issues
    task t_hold_freeze;
        @(negedge ref_clk);
        chk1("done idle", 1'b0, done_reg);
        chk64("result hold", 64'he, result_reg);
        clk_en = 1'b0;
        pipe_model_inst.issue(bitmanip_pkg::OP_SH1ADD, 64'h1, 64'h1, 7'h0);
        chk64("frozen result", 64'he, pipe_model_inst.wb_result);
        chk1("frozen done", 1'b0, pipe_model_inst.wb_done);
        clk_en = 1'b1;
    endtask : t_hold_freeze

    // Reset in mid-run clears every output, each seen nonzero just before
    task t_reset_mid;
        run(bitmanip_pkg::OP_RORI, 64'hf, 64'h0, 7'h40, 64'h0, 1'b1);
        srst = 1'b1;
        @(negedge ref_clk);
        srst = 1'b0;
        chk1("reset done", 1'b0, done_reg);
        chk1("reset illegal", 1'b0, illegal_reg);
        run(bitmanip_pkg::OP_ROL, 64'h1, 64'h1, 7'h0, 64'h2);
        srst = 1'b1;
        @(negedge ref_clk);
        srst = 1'b0;
        chk64("reset result", 64'h0, result_reg);
    endtask : t_reset_mid

    // ==========================================
    // Main sequence and watchdog
    initial begin
        srst = 1'b1;
        clk_en = 1'b1;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        srst = 1'b0;
        chk64("reset result", 64'h0, result_reg);
        t_zba();
        t_logic();
        t_count();
        t_minmax_ext();
        t_rotate();
        t_single_bit();
        t_clmul();
        t_refused();
        t_hold_freeze();
        t_reset_mid();
        close_out();
    end

    initial begin
        repeat (2000) @(posedge ref_clk);
        n_fail++;
        close_out();
    end
endmodule : bitmanip_execution_unit_bench
`default_nettype wire
